/* File: design/isl_corr_rom.sv */
// Correction table: cosine of slope sector times sine of lower angle field.
// Assumes isl_pkg is compiled first; purely combinational read.
module isl_corr_rom #(
  parameter int OUT_W    = 12,
  parameter bit HALF_ERR = 1'b0
) (
  input  wire logic [isl_pkg::SLOPE_W-1:0] i_slope, // Coarse slope index
  input  wire logic [isl_pkg::LOWER_W-1:0] i_lower, // Lower angle field
  output logic      [isl_pkg::CORR_W-1:0]  o_word   // Correction word
);

  localparam real SECTOR_DEG = isl_pkg::QUADRANT_DEG / real'(isl_pkg::SLOPE_SECTORS);
  localparam real STEP_DEG = isl_pkg::QUADRANT_DEG / real'(1 << isl_pkg::ANGLE_W);
  localparam real SHIFT_DEG = HALF_ERR ? isl_pkg::HALF_ERR_SHIFT_DEG : 0.0;
  localparam int CORR_CODE_MAX = (1 << isl_pkg::CORR_W) - 1;
  // Largest product the table may ever hold, rounded up to a code
  localparam int CORR_LIMIT =
    $rtoi(isl_pkg::CORR_MAX * (2.0 ** OUT_W) + 0.999);
  localparam int CLAMP =
    (CORR_LIMIT < CORR_CODE_MAX) ? CORR_LIMIT : CORR_CODE_MAX;

  logic [isl_pkg::CORR_W-1:0] table_q [isl_pkg::CORR_DEPTH];

  // Word contents, indexed by {slope, lower}
  function automatic int corr_value(input int idx);
    int s;
    int l;
    real c;
    s = idx >> isl_pkg::LOWER_W;
    l = idx % (1 << isl_pkg::LOWER_W);
    c = isl_pkg::isl_cos_deg(real'(s) * SECTOR_DEG - SHIFT_DEG);
    return isl_pkg::isl_quant(c * isl_pkg::isl_sin_deg(real'(l) * STEP_DEG),
                              OUT_W, CLAMP);
  endfunction : corr_value

  // 16 sectors by 8 segments = 128 words of 8 bits
  for (genvar k = 0; k < isl_pkg::CORR_DEPTH; k++) begin : g_word
    localparam logic [isl_pkg::CORR_W-1:0] VAL = isl_pkg::CORR_W'(corr_value(k));
    assign table_q[k] = VAL;
  end

  assign o_word = table_q[{i_slope, i_lower}];

endmodule : isl_corr_rom

/* File: design/isl_dummy_unused.sv */
// Holds no logic; every module of the sine lookup lives in a file of its own.
// Assumes nothing of its surroundings.

/* File: design/isl_pkg.sv */
// Constants and shared math for the interpolating sine lookup.
// Assumes elaboration-time real arithmetic for table contents; no runtime reals.
package isl_pkg;

  // Angle word layout
  localparam int ANGLE_W = 11;
  localparam int UPPER_W = 8;
  localparam int LOWER_W = 3;
  localparam int SLOPE_W = 4;
  localparam int UPPER_LSB = LOWER_W;
  localparam int SLOPE_LSB = UPPER_W - SLOPE_W;

  // Table shapes
  localparam int COARSE_DEPTH = 1 << UPPER_W;
  localparam int CORR_DEPTH = 128;
  localparam int CORR_W = 8;
  localparam int CORR_STD_BITS = 5;
  localparam int SLOPE_SECTORS = 1 << SLOPE_W;

  // Output formats
  localparam int STD_OUT_W = 12;
  localparam int EXT_OUT_W = 15;

  // Angle figures in degrees
  localparam real QUADRANT_DEG = 90.0;
  localparam real SECTOR_NOM_DEG = 5.63;
  localparam real HALF_ERR_SHIFT_DEG = 2.81;
  localparam real CORR_MAX = 0.00539;
  localparam real PI = 3.14159265358979;
  localparam int SIN_TERMS = 10;

  // Upper and lower fields of an angle word
  function automatic logic [UPPER_W-1:0] isl_upper(input logic [ANGLE_W-1:0] angle);
    return angle[ANGLE_W-1:UPPER_LSB];
  endfunction : isl_upper

  function automatic logic [LOWER_W-1:0] isl_lower(input logic [ANGLE_W-1:0] angle);
    return angle[LOWER_W-1:0];
  endfunction : isl_lower

  // Taylor series; plenty of terms for a 15-bit result over one quadrant
  function automatic real isl_sin_deg(input real deg);
    real x;
    real t;
    real s;
    x = deg * PI / 180.0;
    t = x;
    s = x;
    for (int k = 1; k < SIN_TERMS; k++) begin
      t = -t * x * x / real'((2 * k) * (2 * k + 1));
      s = s + t;
    end
    return s;
  endfunction : isl_sin_deg

  function automatic real isl_cos_deg(input real deg);
    return isl_sin_deg(QUADRANT_DEG - deg);
  endfunction : isl_cos_deg

  // Round a fraction to a code of w bits, clamped to 0 through max_code
  function automatic int isl_quant(input real v, input int w, input int max_code);
    int c;
    c = $rtoi(v * (2.0 ** w) + 0.5);
    if (c > max_code) begin
      c = max_code;
    end
    if (c < 0) begin
      c = 0;
    end
    return c;
  endfunction : isl_quant

endpackage : isl_pkg

/* File: design/isl_sine_interp.sv */
// Interpolating sine generator: coarse sine table plus correction table.
// Assumes upstream logic presents angle words synchronous to i_sys_clk.
//
// Operation
// - Angle splits into upper 8 bits and lower 3 bits.
// - Coarse table, addressed by upper field, gives 12-bit sine of coarse angle.
// - Correction term comes from its own table, never above 0.00539.
// - Correction table is 128 by 8; five low bits used normally.
// - Slope index is top 4 bits of upper field, 5.63 degrees per step.
// - Correction word is sector cosine times sine of lower field.
// - Output is coarse sine plus correction, unsigned fraction add.
// - Sixteen sectors, sixteen subsections each, eight segments each.
// - Lower field zero gives zero correction, output equals coarse sine.
// - Optional sector cosine taken 2.81 degrees lower to halve error.
// - Extended form widens coarse table, uses all eight correction bits.
// - Output MSB weighs one half, each further bit half as much.
module isl_sine_interp #(
  parameter int OUT_W    = isl_pkg::STD_OUT_W, // 12 standard, 15 extended
  parameter bit HALF_ERR = 1'b0                 // Shifted-cosine correction
) (
  input  wire logic                          i_sys_clk,     // System clock, 250 MHz
  input  wire logic                          i_sys_rst,     // Async reset, active high
  input  wire logic                          i_angle_valid, // Angle word present
  input  wire logic [isl_pkg::ANGLE_W-1:0]   i_angle,       // 0 to 90 degrees, 11 bits
  output logic                               o_valid,       // Result present
  output logic      [OUT_W-1:0]              o_sine,        // Sine as binary fraction
  output logic      [OUT_W-1:0]              o_coarse,      // Coarse sine alone
  output logic      [isl_pkg::CORR_W-1:0]    o_correction,  // Correction added
  output logic      [isl_pkg::SLOPE_W-1:0]   o_slope_index, // Coarse slope index
  output logic                               o_exact        // Lower field was zero
);

  localparam bit EXTENDED = (OUT_W >= isl_pkg::EXT_OUT_W);
  localparam int SUM_W = OUT_W + 1;
  localparam int COARSE_CODE_MAX = (1 << OUT_W) - 1;
  localparam real SUBSECT_DEG = isl_pkg::QUADRANT_DEG / real'(isl_pkg::COARSE_DEPTH);
  localparam logic [isl_pkg::CORR_W-1:0] STD_MASK =
    isl_pkg::CORR_W'((1 << isl_pkg::CORR_STD_BITS) - 1);
  localparam logic [isl_pkg::CORR_W-1:0] EXT_MASK = '1;
  localparam logic [isl_pkg::CORR_W-1:0] CORR_MASK = EXTENDED ? EXT_MASK : STD_MASK;

  typedef struct packed {
    logic                        valid;
    logic [OUT_W-1:0]            sine;
    logic [OUT_W-1:0]            coarse;
    logic [isl_pkg::CORR_W-1:0]  corr;
    logic [isl_pkg::SLOPE_W-1:0] slope;
    logic                        exact;
  } isl_state_t;

  localparam isl_state_t RESET_STATE = '0;

  isl_state_t state;
  isl_state_t next_state;

  logic [isl_pkg::UPPER_W-1:0] upper;
  logic [isl_pkg::LOWER_W-1:0] lower;
  logic [isl_pkg::SLOPE_W-1:0] slope;
  logic [OUT_W-1:0]            coarse_word;
  logic [isl_pkg::CORR_W-1:0]  corr_word;
  logic [isl_pkg::CORR_W-1:0]  corr_used;
  logic [SUM_W-1:0]            sum;

  // Coarse sine of each subsection; cos of the lower field is taken as one,
  // which costs at most 0.00002 relative.
  logic [OUT_W-1:0] coarse_rom [isl_pkg::COARSE_DEPTH];

  for (genvar k = 0; k < isl_pkg::COARSE_DEPTH; k++) begin : g_coarse
    localparam logic [OUT_W-1:0] VAL = OUT_W'(isl_pkg::isl_quant(
      isl_pkg::isl_sin_deg(real'(k) * SUBSECT_DEG), OUT_W, COARSE_CODE_MAX));
    assign coarse_rom[k] = VAL;
  end

  always_comb begin
    upper = isl_pkg::isl_upper(i_angle);
    lower = isl_pkg::isl_lower(i_angle);
    slope = upper[isl_pkg::UPPER_W-1:isl_pkg::SLOPE_LSB];
    coarse_word = coarse_rom[upper];
  end

  isl_corr_rom #(
    .OUT_W    (OUT_W),
    .HALF_ERR (HALF_ERR)
  ) u_corr_rom (
    .i_slope (slope),
    .i_lower (lower),
    .o_word  (corr_word)
  );

  always_comb begin
    next_state = state;
    // Standard width keeps only the five low bits; extended keeps all eight
    corr_used = corr_word & CORR_MASK;
    if (lower == '0) begin
      corr_used = '0;
    end
    // Both terms share the same 2^-OUT_W weighting of the LSB
    sum = {1'b0, coarse_word} + SUM_W'(corr_used);
    next_state.valid = i_angle_valid;
    if (i_angle_valid) begin
      // Near 90 degrees the sum can reach one, which the fraction cannot hold
      if (sum[OUT_W]) begin
        next_state.sine = '1;
      end else begin
        next_state.sine = sum[OUT_W-1:0];
      end
      next_state.coarse = coarse_word;
      next_state.corr = corr_used;
      next_state.slope = slope;
      next_state.exact = (lower == '0);
    end
  end

  // Result holds its last value while no new angle arrives
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign o_valid = state.valid;
  assign o_sine = state.sine;
  assign o_coarse = state.coarse;
  assign o_correction = state.corr;
  assign o_slope_index = state.slope;
  assign o_exact = state.exact;

endmodule : isl_sine_interp

/* File: dv/isl_angle_src.sv */
// Upstream angle source model feeding the sine block.
// Assumes the bench sets a request just after a rising edge.
module isl_angle_src (
  input  wire logic        i_clk,   // Clock
  input  wire logic        i_req,   // Send a word
  input  wire logic [10:0] i_word,  // Word to send
  output logic             o_valid, // Angle valid
  output logic      [10:0] o_angle  // Angle word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_valid = 1'b0;
  initial o_angle = 11'h0;
  // Idle data is inverted so a block that ignores valid sees junk
  always @(negedge i_clk) begin
    o_valid <= i_req;
    o_angle <= i_req ? i_word : ~o_angle;
  end
endmodule : isl_angle_src

/* File: dv/isl_checker.sv */
// Assertions on the ports of the sine lookup.
// Assumes binding into isl_sine_interp with its OUT_W.
module isl_checker #(
  parameter int OUT_W = 12
) (
  input wire logic              i_sys_clk,     // Clock
  input wire logic              i_sys_rst,     // Reset
  input wire logic              i_angle_valid, // Angle in
  input wire logic [10:0]       i_angle,       // Angle word
  input wire logic              o_valid,       // Result flag
  input wire logic [OUT_W-1:0]  o_sine,        // Sum
  input wire logic [OUT_W-1:0]  o_coarse,      // Coarse
  input wire logic [7:0]        o_correction,  // Correction
  input wire logic [3:0]        o_slope_index, // Slope
  input wire logic              o_exact        // Lower zero
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // Own bound on the correction code, ceil of the largest term
  localparam int CAP = (OUT_W == 12) ? 23 : 177;
  chk_valid_delay: assert property (i_angle_valid |=> o_valid)
    else $error("late result");
  chk_idle_hold: assert property (!i_angle_valid |=> !o_valid && $stable(o_sine))
    else $error("idle changed result");
  chk_slope_field: assert property (i_angle_valid
    |=> o_slope_index == $past(i_angle[10:7]))
    else $error("bad slope index");
  chk_exact_flag: assert property (i_angle_valid
    |=> o_exact == ($past(i_angle[2:0]) == 3'h0))
    else $error("bad exact flag");
  chk_zero_corr: assert property (o_valid && o_exact
    |-> o_correction == 8'h0 && o_sine == o_coarse)
    else $error("correction on exact angle");
  chk_sum_value: assert property (o_valid && (o_coarse + o_correction < 2 ** OUT_W)
    |-> o_sine == o_coarse + o_correction)
    else $error("bad sum");
  // The full-scale value cannot be held, so an overflowing sum must pin to all ones
  chk_sum_sat: assert property (o_valid && (o_coarse + o_correction >= 2 ** OUT_W)
    |-> o_sine == '1)
    else $error("sum did not saturate");
  chk_corr_cap: assert property (o_valid |-> o_correction <= CAP)
    else $error("correction too large");
  chk_coarse_same: assert property (i_angle_valid && $past(i_angle_valid)
    && i_angle[10:3] == $past(i_angle[10:3]) |=> $stable(o_coarse))
    else $error("coarse depends on lower field");
endmodule : isl_checker

bind isl_sine_interp isl_checker #(.OUT_W(OUT_W)) isl_checker_inst (.i_sys_clk, .i_sys_rst,
  .i_angle_valid, .i_angle, .o_valid, .o_sine, .o_coarse, .o_correction, .o_slope_index, .o_exact);

/* File: dv/tb.sv */
// Self-checking bench for the standard 12-bit sine lookup.
// Assumes the source model and checker are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam real PI = 3.14159265358979;
  typedef struct {logic [10:0] a; logic [11:0] s;} isl_row_t;
  logic        clk, rst, req, vld, o_vld, exact;
  logic [10:0] word, angle;
  logic [11:0] sine, coarse;
  logic [7:0]  corr;
  logic [3:0]  slope;
  int          n_mismatch = 0;
  int          total_checks = 0;
  isl_row_t    rows [10];
  logic [10:0] ang [10] = '{11'h0, 11'h1, 11'h8, 11'hf, 11'h400, 11'h407, 11'h7ff, 11'h7,
                            11'h280, 11'h7f};
  isl_angle_src isl_angle_src_inst (.i_clk(clk), .i_req(req), .i_word(word), .o_valid(vld),
    .o_angle(angle));
  isl_sine_interp isl_sine_interp_inst (.i_sys_clk(clk), .i_sys_rst(rst), .i_angle_valid(vld),
    .i_angle(angle), .o_valid(o_vld), .o_sine(sine), .o_coarse(coarse), .o_correction(corr),
    .o_slope_index(slope), .o_exact(exact));
  function automatic int ref_coarse(logic [10:0] a);
    int c;
    c = $rtoi($sin(a[10:3] * PI / 512.0) * 4096.0 + 0.5);
    return (c > 4095) ? 4095 : c;
  endfunction : ref_coarse
  // Only five bits reach the 12-bit sum
  function automatic int ref_corr(logic [10:0] a);
    int c;
    c = $rtoi($cos(a[10:7] * PI / 32.0) * $sin(a[2:0] * PI / 4096.0) * 4096.0 + 0.5);
    c = (c > 23) ? 23 : c;
    return c & 'h1f;
  endfunction : ref_corr
  task automatic cmp_eq(logic [11:0] got, logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_eq
  // Table rounding may land one code either way
  task automatic cmp_near(logic [11:0] got, logic [11:0] exp);
    if ((got === exp + 12'h1 && exp !== 12'hfff) || (got === exp - 12'h1 && exp !== 12'h0))
      cmp_eq(got, got);
    else
      cmp_eq(got, exp);
  endtask : cmp_near
  task automatic check_row(isl_row_t r);
    cmp_eq(12'(o_vld), 12'h1);
    cmp_eq(12'(slope), 12'(r.a[10:7]));
    cmp_eq(12'(exact), 12'(r.a[2:0] == 3'h0));
    cmp_near(coarse, 12'(ref_coarse(r.a)));
    cmp_near(12'(corr), 12'(ref_corr(r.a)));
    cmp_near(sine, r.s);
  endtask : check_row
  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #800;
    n_mismatch++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    req = 1'b0;
    word = 11'h0;
    for (int i = 0; i < 10; i++) begin
      rows[i].a = ang[i];
      rows[i].s = 12'((ref_coarse(ang[i]) + ref_corr(ang[i]) > 4095) ? 4095
                      : ref_coarse(ang[i]) + ref_corr(ang[i]));
    end
    repeat (3) @(negedge clk);
    cmp_eq(12'(o_vld), 12'h0);
    cmp_eq(sine, 12'h0);
    rst = 1'b0;
    for (int i = 0; i <= 10; i++) begin
      @(posedge clk);
      req <= (i < 10);
      word <= ang[i % 10];
      #1;
      if (i > 0) check_row(rows[i - 1]);
    end
    @(posedge clk);
    #1;
    cmp_eq(12'(o_vld), 12'h0);
    cmp_near(sine, rows[9].s);
    @(negedge clk);
    rst = 1'b1;
    #1;
    cmp_eq(sine, 12'h0);
    @(negedge clk);
    rst = 1'b0;
    @(posedge clk);
    req <= 1'b1;
    word <= ang[5];
    @(posedge clk);
    req <= 1'b0;
    #1;
    check_row(rows[5]);
    stop_test();
  end
endmodule : tb
